// [pkg/sro_pkg.sv]
// Constants and types for the converter's conversion-start and serial readout port
// Contract
// - A rising edge on convert_strobe starts a new conversion of the sampled input.
// - That same rising edge releases serial_result_out to high impedance.
// - After a conversion the block returns to acquisition and powers down until the next start.
// - When convert_strobe goes low the most significant result bit appears on serial_result_out.
// - The host gives shift-clock falling edges; each moves the output to the next lower bit.
// - Each output bit stays valid across both shift-clock edges; the host may sample on either. The msb sees only the first falling edge.
// - Conversion runs on the internal clock and needs no shift-clock activity.
// - The result is a 16-bit word resolved msb first in binary-weighted steps down to one lsb.
// - The code is straight binary, all ones above full scale and all zeros below zero.
package sro_pkg;
  // Result width
  localparam int RESULT_W = 16;
  // Internal clock period
  localparam int CLK_PERIOD_NS = 20;
  // Least settling time of trial level and comparator
  localparam int CMP_SETTLE_NS = 60;
  // Flops in the comparator synchroniser
  localparam int CMP_SYNC_STAGES = 2;
  // Cycles spent on each trial bit, settling rounded up plus synchroniser
  localparam int CMP_WAIT_CYC = (CMP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                + CMP_SYNC_STAGES;
  // Reset values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] TRIAL_RESET = 16'h0000;

  // Conversion sequencer states
  typedef enum logic [0:0] {
    SRO_ACQUIRE,
    SRO_TRIAL
  } sro_state_t;
endpackage : sro_pkg

// [logic/sro_shifter.sv]
// Shift-clock side of the serial readout: bit index and output bit
`timescale 1ns/10ps
module sro_shifter #(
  parameter int RESULT_W = sro_pkg::RESULT_W
) (
  input wire logic shift_clk,
  input wire logic frame_clear,
  input wire logic [RESULT_W-1:0] result_word,
  output logic serial_bit
);
  localparam int IDX_W = $clog2(RESULT_W);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(RESULT_W - 1);

  logic [IDX_W-1:0] bit_idx;
  logic lower_bit;

  // Frame restarts on the strobe itself, since this clock may stand still between frames
  always_ff @(negedge shift_clk or posedge frame_clear) begin
    if (frame_clear) begin
      bit_idx <= '0;
      lower_bit <= 1'b0;
    end else if (bit_idx != LAST_IDX) begin
      bit_idx <= bit_idx + 1'b1;
      lower_bit <= result_word[LAST_IDX - 1'b1 - bit_idx];
    end
  end

  // Result word is held still through the readout, so reading it here is quasi-static
  assign serial_bit = (bit_idx == '0) ? result_word[RESULT_W-1] : lower_bit;
endmodule : sro_shifter

// [logic/sro_adc_readout.sv]
// Successive-approximation sequencer and serial readout of the converter
`timescale 1ns/10ps
module sro_adc_readout #(
  parameter int RESULT_W = sro_pkg::RESULT_W,
  parameter int WAIT_CYC = sro_pkg::CMP_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic convert_strobe,
  input wire logic comparator_high,
  output logic serial_result_out,
  output logic serial_result_oe,
  output logic [RESULT_W-1:0] dac_trial,
  output logic track_enable,
  output logic power_down,
  output logic conversion_busy
);
  localparam int POS_W = $clog2(RESULT_W);
  localparam int WAIT_W = $clog2(WAIT_CYC + 1);
  localparam logic [POS_W-1:0] TOP_POS = POS_W'(RESULT_W - 1);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(WAIT_CYC - 1);

  // Synchroniser lanes, one per asynchronous pin
  localparam int N_ASYNC = 2;
  localparam int LANE_STROBE = 0;
  localparam int LANE_CMP = 1;

  sro_pkg::sro_state_t state;
  logic [N_ASYNC-1:0] async_in;
  logic [N_ASYNC-1:0] sync_meta;
  logic [N_ASYNC-1:0] sync_out;
  logic cnv_sync;
  logic cnv_prev;
  logic cmp_sync;
  logic start_pulse;
  logic start_take;
  logic step_down;
  logic last_step;
  logic [POS_W-1:0] bit_pos;
  logic [WAIT_W-1:0] wait_cnt;
  logic [RESULT_W-1:0] result;
  logic result_ready;
  logic in_reset;
  logic frame_clear;

  // One-hot weight of a bit position, used for setting and clearing trials
  function automatic logic [RESULT_W-1:0] weight(input logic [POS_W-1:0] pos);
    weight = {{(RESULT_W-1){1'b0}}, 1'b1} << pos;
  endfunction : weight

  // Trial word after a decision; a low comparator drops the bit under test
  function automatic logic [RESULT_W-1:0] decide(input logic [RESULT_W-1:0] trial,
                                                 input logic [POS_W-1:0] pos,
                                                 input logic keep);
    decide = keep ? trial : (trial & ~weight(pos));
  endfunction : decide

  // Last cycle of a trial window, where the synchronised comparator is judged
  function automatic logic window_end(input logic [WAIT_W-1:0] cnt);
    window_end = (cnt == WAIT_LAST);
  endfunction : window_end

  // Pins in lane order; the comparator is an analog level, the strobe a host pin
  assign async_in[LANE_STROBE] = convert_strobe;
  assign async_in[LANE_CMP] = comparator_high;

  // Two flops per pin; only the second flop is read by any logic
  for (genvar gi = 0; gi < N_ASYNC; gi++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        sync_meta[gi] <= 1'b0;
        sync_out[gi] <= 1'b0;
      end else begin
        sync_meta[gi] <= async_in[gi];
        sync_out[gi] <= sync_meta[gi];
      end
    end
  end

  assign cnv_sync = sync_out[LANE_STROBE];
  assign cmp_sync = sync_out[LANE_CMP];

  // Previous strobe level; resets to the idle low level so reset makes no edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnv_prev <= 1'b0;
    end else begin
      cnv_prev <= cnv_sync;
    end
  end

  assign start_pulse = cnv_sync & ~cnv_prev;
  // Starts while converting are ignored, so only the idle state takes them
  assign start_take = start_pulse & (state == sro_pkg::SRO_ACQUIRE);
  // A window closes with a lower bit still to try
  assign step_down = (state == sro_pkg::SRO_TRIAL) & window_end(wait_cnt) & (bit_pos != '0);
  // The lsb window closes and the conversion is over
  assign last_step = (state == sro_pkg::SRO_TRIAL) & window_end(wait_cnt) & (bit_pos == '0);

  // Sequencer state: one trial per bit, msb first, on the internal clock only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= sro_pkg::SRO_ACQUIRE;
    end else begin
      unique case (state)
        sro_pkg::SRO_ACQUIRE: begin
          if (start_pulse) begin
            state <= sro_pkg::SRO_TRIAL;
          end
        end
        sro_pkg::SRO_TRIAL: begin
          if (last_step) begin
            state <= sro_pkg::SRO_ACQUIRE;
          end
        end
      endcase
    end
  end

  // Settling counter; every bit gets the same window so the comparator has settled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_cnt <= '0;
    end else if (start_take || step_down || last_step) begin
      wait_cnt <= '0;
    end else if (state == sro_pkg::SRO_TRIAL) begin
      wait_cnt <= wait_cnt + 1'b1;
    end
  end

  // Bit under test walks from the msb down to the lsb
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_pos <= TOP_POS;
    end else if (start_take) begin
      bit_pos <= TOP_POS;
    end else if (step_down) begin
      bit_pos <= bit_pos - 1'b1;
    end
  end

  // Trial level: keep or drop the bit under test, then raise the next lower one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dac_trial <= sro_pkg::TRIAL_RESET;
    end else if (start_take) begin
      dac_trial <= weight(TOP_POS);
    end else if (step_down) begin
      dac_trial <= decide(dac_trial, bit_pos, cmp_sync) | weight(bit_pos - 1'b1);
    end
  end

  // Result word: loaded once by the last decision, held still for the readout
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result <= sro_pkg::RESULT_RESET;
    end else if (last_step) begin
      result <= decide(dac_trial, bit_pos, cmp_sync);
    end
  end

  // Result flag: set by the last decision, cleared by a start that is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_ready <= 1'b0;
    end else if (last_step) begin
      result_ready <= 1'b1;
    end else if (start_take) begin
      result_ready <= 1'b0;
    end
  end

  // Track switch: open for the whole conversion, closed again for acquisition
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      track_enable <= 1'b1;
    end else if (start_take) begin
      track_enable <= 1'b0;
    end else if (last_step) begin
      track_enable <= 1'b1;
    end
  end

  // Power: awake only while converting, so supply current follows the sample rate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_down <= 1'b1;
    end else if (start_take) begin
      power_down <= 1'b0;
    end else if (last_step) begin
      power_down <= 1'b1;
    end
  end

  // Busy flag spans exactly the trial windows of one conversion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conversion_busy <= 1'b0;
    end else if (start_take) begin
      conversion_busy <= 1'b1;
    end else if (last_step) begin
      conversion_busy <= 1'b0;
    end
  end

  // Driver enable drops on the strobe edge itself, not after the synchroniser
  always_ff @(posedge clk or posedge convert_strobe) begin
    if (convert_strobe) begin
      serial_result_oe <= 1'b0;
    end else if (!rst_n) begin
      serial_result_oe <= 1'b0;
    end else if (!cnv_sync && result_ready && state == sro_pkg::SRO_ACQUIRE) begin
      serial_result_oe <= 1'b1;
    end
  end

  // Holds the shift side cleared through reset, when the strobe may never have risen
  always_ff @(posedge clk) begin
    in_reset <= !rst_n;
  end

  assign frame_clear = convert_strobe | in_reset;

  // Shift-clock domain: bit index and lower bits
  sro_shifter #(
    .RESULT_W(RESULT_W)
  ) u_shifter (
    .shift_clk(shift_clk),
    .frame_clear(frame_clear),
    .result_word(result),
    .serial_bit(serial_result_out)
  );
endmodule : sro_adc_readout

// [tb/sro_adc_readout_asserts.sv]
// Checker on the converter readout ports
`timescale 1ns/10ps
module sro_adc_readout_asserts #(
  parameter int RESULT_W = 16,
  parameter int WAIT_CYC = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic convert_strobe,
  input wire logic serial_result_oe,
  input wire logic [RESULT_W-1:0] dac_trial,
  input wire logic track_enable,
  input wire logic power_down,
  input wire logic conversion_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Busy length, judged when busy drops
  int cnt;
  always_ff @(posedge clk) begin
    cnt <= (!rst_n || !conversion_busy) ? 0 : cnt + 1;
  end
  oe_release_a: assert property ($rose(convert_strobe) |-> !serial_result_oe)
    else $error("output enabled after start");
  start_busy_a: assert property (
    $rose(convert_strobe) && !conversion_busy |-> ##[1:5] conversion_busy)
    else $error("start not taken");
  trial_msb_a: assert property (
    $rose(conversion_busy) |-> dac_trial == 16'h8000 && !track_enable && !power_down)
    else $error("bad first trial");
  busy_len_a: assert property ($fell(conversion_busy) |-> cnt == RESULT_W * WAIT_CYC)
    else $error("wrong conversion length");
  done_power_a: assert property ($fell(conversion_busy) |-> power_down && track_enable)
    else $error("no power down after conversion");
  busy_quiet_a: assert property (conversion_busy |-> !serial_result_oe)
    else $error("driving during conversion");
  readout_oe_a: assert property (
    $fell(convert_strobe) && !conversion_busy |-> ##[1:5] serial_result_oe)
    else $error("no output after strobe low");
  down_idle_a: assert property (power_down |-> !conversion_busy && track_enable)
    else $error("powered down while busy");
endmodule : sro_adc_readout_asserts

bind sro_adc_readout sro_adc_readout_asserts #(.RESULT_W(RESULT_W), .WAIT_CYC(WAIT_CYC)) chk (
  .clk(clk), .rst_n(rst_n), .convert_strobe(convert_strobe),
  .serial_result_oe(serial_result_oe), .dac_trial(dac_trial), .track_enable(track_enable),
  .power_down(power_down), .conversion_busy(conversion_busy));

// [tb/sro_host_model.sv]
// Host model: starts a conversion and shifts the word out
`timescale 1ns/10ps
module sro_host_model (
  output logic convert_strobe,
  output logic shift_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic conversion_busy
);
  // Released line shows the inverse, so a read before the driver is on goes wrong
  logic line_level;
  assign line_level = serial_result_oe ? serial_result_out : ~serial_result_out;
  // Shift clock idles high, runs only within frames
  initial begin
    convert_strobe = 1'b0;
    shift_clk = 1'b1;
  end
  task automatic read_word(output logic [15:0] w, output logic [15:0] wf);
    int n;
    convert_strobe = 1'b1;
    for (n = 0; n < 50 && !conversion_busy; n++) #20;
    // Strobe stays high until busy drops
    for (n = 0; n < 300 && conversion_busy; n++) #20;
    convert_strobe = 1'b0;
    for (n = 0; n < 50 && !serial_result_oe; n++) #20;
    w[15] = line_level;
    // Falling edge advances; each bit taken at its rising edge and at the fall ending it
    for (n = 14; n >= 0; n--) begin
      wf[n + 1] = line_level;
      shift_clk = 1'b0;
      #32 shift_clk = 1'b1;
      w[n] = line_level;
      #32;
    end
    // One spare fall: the lsb must hold, and is taken at that edge
    wf[0] = line_level;
    shift_clk = 1'b0;
    #32 shift_clk = 1'b1;
  endtask : read_word
endmodule : sro_host_model

// [tb/tb_sar_adc_serial_readout.sv]
// Bench for the converter readout port
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module tb_sar_adc_serial_readout;
  logic clk = 1'b0, rst_n = 1'b0;
  logic cs, sclk, sout, oe, tl, pd, busy;
  logic [15:0] trial, got, got_fall;
  logic [16:0] vin = 17'h00000;
  int num_errors = 0, total_checks = 0;
  initial forever #10 clk = ~clk;
  sro_adc_readout dut (.clk(clk), .rst_n(rst_n), .shift_clk(sclk), .convert_strobe(cs),
    .comparator_high(vin >= {1'b0, trial}), .serial_result_out(sout),
    .serial_result_oe(oe), .dac_trial(trial), .track_enable(tl), .power_down(pd),
    .conversion_busy(busy));
  sro_host_model host (.convert_strobe(cs), .shift_clk(sclk), .serial_result_out(sout),
    .serial_result_oe(oe), .conversion_busy(busy));
  // One conversion of level v, then the word read back
  task automatic conv(input logic [16:0] v, input logic [15:0] e);
    @(posedge clk) #2 vin = v;
    host.read_word(got, got_fall);
    `CHK(oe, 1'b1)
    `CHK(got, e)
    `CHK(got_fall, e)
  endtask : conv
  task automatic scn_codes();
    conv(17'h08000, 16'h8000);
    conv(17'h07fff, 16'h7fff);
    conv(17'h0a5c3, 16'ha5c3);
  endtask : scn_codes
  task automatic scn_saturate();
    conv(17'h1ffff, 16'hffff);
    conv(17'h00000, 16'h0000);
  endtask : scn_saturate
  task automatic scn_power();
    conv(17'h00001, 16'h0001);
    `CHK({pd, tl, busy, oe}, 4'b1101)
  endtask : scn_power
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    #200000 num_errors++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #7 scn_codes();
    scn_saturate();
    scn_power();
    conclude();
  end
endmodule : tb_sar_adc_serial_readout
